/* File: common/tct_pkg.sv */
package tct_pkg;

  // register word addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CNTH   = 8'h04;
  localparam logic [7:0] ADDR_CNTL   = 8'h08;
  localparam logic [7:0] ADDR_MODH   = 8'h0C;
  localparam logic [7:0] ADDR_MODL   = 8'h10;
  localparam logic [7:0] ADDR_CH0CTL = 8'h14;
  localparam logic [7:0] ADDR_CH1CTL = 8'h18;
  localparam logic [7:0] ADDR_CH0VH  = 8'h1C;
  localparam logic [7:0] ADDR_CH0VL  = 8'h20;
  localparam logic [7:0] ADDR_CH1VH  = 8'h24;
  localparam logic [7:0] ADDR_CH1VL  = 8'h28;
  localparam logic [7:0] ADDR_BRKCFG = 8'h2C;

  // timer_status_control fields
  localparam int CTRL_FLAG  = 7;
  localparam int CTRL_IE    = 6;
  localparam int CTRL_STOP  = 5;
  localparam int CTRL_CRST  = 4;
  localparam int CTRL_PS_LO = 0;

  // channel status_control fields
  localparam int CHC_FLAG   = 7;
  localparam int CHC_IE     = 6;
  localparam int CHC_MSB    = 5;
  localparam int CHC_MSA    = 4;
  localparam int CHC_ELS_LO = 2;

  // break config field
  localparam int BRK_CLREN  = 0;

  localparam logic [2:0]  PS_EXT    = 3'h7;
  localparam logic [1:0]  ELS_PORT  = 2'h0;
  localparam logic [1:0]  ELS_TOG   = 2'h1;
  localparam logic [1:0]  ELS_CLR   = 2'h2;
  localparam logic [1:0]  ELS_SET   = 2'h3;
  localparam logic [15:0] RST_MOD   = 16'hFFFF;
  localparam logic        RST_STOP  = 1'b1;
  localparam logic [15:0] CNT_ZERO  = 16'h0000;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } tct_apb_req_s;

  typedef struct packed {
    logic        flag;
    logic        arm;
    logic        ie;
    logic        msB;
    logic        msA;
    logic [1:0]  els;
    logic [15:0] val;
    logic        inh;
    logic        pinPrev;
    logic        pinOut;
    logic        pinOe;
    logic        irq;
  } tct_chan_s;

  typedef struct packed {
    logic [6:0]   pre;
    logic [15:0]  cnt;
    logic [15:0]  mod;
    logic         modInh;
    logic [7:0]   lowBuf;
    logic         lowLat;
    logic         ovf;
    logic         ovfArm;
    logic         ovfIe;
    logic         ovfIrq;
    logic         stop;
    logic [2:0]   ps;
    logic         break_clear_enable;
    logic         extPrev;
    logic         actSel;
    logic         lastWr;
    tct_chan_s [1:0] ch;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
  } tct_state_s;

endpackage : tct_pkg

/* File: hdl/tct_timer.sv */
// Function
// - counter halts while the system is in break
// - with break-clear enabled, flags cleared in break stay cleared
// - break-clear off: accesses in break leave flags; pending clear finishes after
// - prescale codes 0..6 divide bus clock by 1 to 64; reset clears
// - on second timer, prescale code 7 counts external clock edges
// - each channel capture or compare; only channel 0 supports buffered mode
// - overflow flag sets at modulo; read-then-zero-write clears; one ignored
// - overflow between read and zero write cancels the clear
// - overflow interrupt requested when flag and enable are set and no modulo high write is pending
// - stop bit freezes counting; reset sets it
// - counter reset bit clears counter and prescaler, self-clears, reads 0
// - stop plus counter reset in one write holds counter at zero
// - high byte read latches low byte until low byte is read
// - at modulo value counter sets flag and restarts from zero
// - modulo high write suppresses overflow until low write; reset all ones
// - channel flag on capture edge or compare match
// - channel flag clears by read-then-zero-write; new event cancels clear
// - channel interrupt requested when flag and enable are set
// - buffered select in channel 0 disables channel 1 register and pin
// - mode A picks compare or capture; with edge select 0 sets preset level
// - edge select codes rising/falling/both, or toggle/clear/set on match
// - value high write blocks compares; value high read blocks captures
`timescale 1ns/1ps
`default_nettype none

module tct_timer #(
  parameter bit HAS_EXT_CLK = 1'b1
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire tct_pkg::tct_apb_req_s apbReq,
  output logic                      pready,
  output logic                      pslverr,
  output logic [31:0]               prdata,
  input  wire logic                 breakActive,
  input  wire logic                 extClk,
  input  wire logic [1:0]           chIn,
  output logic [1:0]                chOut,
  output logic [1:0]                chOe,
  output logic                      ovfIrq,
  output logic [1:0]                chIrq
);
  import tct_pkg::*;

  // all state lives in one registered struct; d is its full next value
  // so every register shares one reset and one clock process
  tct_state_s q;
  tct_state_s d;

  // decoded strobes and events of the current cycle
  // all are recomputed every cycle, none of them is stored
  logic        rdCap;
  logic        wrDone;
  logic        hit;
  logic        brkLock;
  logic        run;
  logic        tick;
  logic        extRise;
  logic [6:0]  mask;
  logic        ovfEv;
  logic        ovfClr;
  logic [7:0]  rdByte;
  logic [7:0]  wb;
  logic [1:0]  chEv;
  logic [1:0]  chClr;
  logic [1:0]  chOn;
  logic [1:0]  capMode;
  logic [1:0]  cmpMode;
  logic [1:0]  pinEdge;
  logic [15:0] cmpVal;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    // only the low byte of the write data is used
    wb = apbReq.pwdata[7:0];
    // data is taken one edge before completion, so read effects go there too
    rdCap = apbReq.psel & apbReq.penable & ~q.pready & ~apbReq.pwrite;
    wrDone = apbReq.psel & apbReq.penable & q.pready & apbReq.pwrite;
    d.pready = apbReq.psel & apbReq.penable & ~q.pready;
    hit = (apbReq.paddr <= ADDR_BRKCFG) && (apbReq.paddr[1:0] == 2'h0);
    // unmapped or unaligned words answer with pslverr, never with a hang
    d.pslverr = apbReq.psel & apbReq.penable & ~q.pready & ~hit;
    // break locks the flags only while break-clear is off
    // flags locked in break
    brkLock = breakActive & ~q.break_clear_enable;
    ovfClr = 1'b0;
    chClr = 2'b00;

    //////////////////////////////////////////////////////////////////////
    // counter path: run, prescale, tick, count and wrap
    // halt in break
    run = ~q.stop & ~breakActive;
    // prescale divide
    // a tick is the cycle in which all selected low prescaler bits are set
    // a select change mid-run may give one period of odd length
    mask = 7'((8'h01 << q.ps) - 8'h01);
    extRise = extClk & ~q.extPrev;
    // the external input is taken as already synchronous to clk
    // so one compare against the last sample finds its rising edge
    // limitation: it must stay low and high for at least one clk each
    d.extPrev = extClk;
    if (q.ps == PS_EXT) begin
      tick = run & extRise & HAS_EXT_CLK;
    end else begin
      tick = run & ((q.pre & mask) == mask);
    end
    if (run) begin
      d.pre = q.pre + 7'h01;
    end
    ovfEv = tick & (q.cnt == q.mod);
    if (tick) begin
      d.cnt = ovfEv ? CNT_ZERO : q.cnt + 16'h0001;
    end
    // the buffered set swaps only at overflow, so no period is torn
    if (ovfEv) begin
      d.actSel = q.lastWr;
    end

    //////////////////////////////////////////////////////////////////////
    // both channels share this code; channel 1 goes quiet when linked
    for (int i = 0; i < 2; i++) begin
      chOn[i] = (i == 0) || !q.ch[0].msB;
      // mode from A and edge select
      capMode[i] = chOn[i] && !q.ch[i].msB && !q.ch[i].msA && (q.ch[i].els != ELS_PORT);
      cmpMode[i] = chOn[i] && (q.ch[i].msB || q.ch[i].msA) && (q.ch[i].els != ELS_PORT);
      // a linked pair compares against the value set written last
      // the choice only changes at an overflow
      // buffered pair uses the active value
      cmpVal = (i == 0 && q.ch[0].msB && q.actSel) ? q.ch[1].val : q.ch[i].val;
      d.ch[i].pinPrev = chIn[i];
      pinEdge[i] = 1'b0;
      // edge codes: 1 rising, 2 falling, 3 either
      // capture edge choice
      case (q.ch[i].els)
        ELS_TOG: pinEdge[i] = chIn[i] & ~q.ch[i].pinPrev;
        ELS_CLR: pinEdge[i] = ~chIn[i] & q.ch[i].pinPrev;
        ELS_SET: pinEdge[i] = chIn[i] ^ q.ch[i].pinPrev;
        default: pinEdge[i] = 1'b0;
      endcase
      chEv[i] = 1'b0;
      if (capMode[i] && pinEdge[i] && !q.ch[i].inh) begin
        chEv[i] = 1'b1;
        d.ch[i].val = q.cnt;
      end
      if (cmpMode[i] && tick && (q.cnt == cmpVal) && !q.ch[i].inh) begin
        chEv[i] = 1'b1;
      end
      // preset level when edge select is 0
      if (q.ch[i].els == ELS_PORT) begin
        d.ch[i].pinOut = ~q.ch[i].msA;
      end else if (cmpMode[i] && chEv[i]) begin
        case (q.ch[i].els)
          ELS_TOG: d.ch[i].pinOut = ~q.ch[i].pinOut;
          ELS_CLR: d.ch[i].pinOut = 1'b0;
          ELS_SET: d.ch[i].pinOut = 1'b1;
          default: d.ch[i].pinOut = q.ch[i].pinOut;
        endcase
      end
      d.ch[i].pinOe = cmpMode[i];
    end

    //////////////////////////////////////////////////////////////////////
    // read mux: bytes sit in bits 7:0, upper bits always zero
    // unmapped words read as zero and raise pslverr
    rdByte = 8'h00;
    case (apbReq.paddr)
      ADDR_CTRL: begin
        rdByte = {q.ovf, q.ovfIe, q.stop, 1'b0, 1'b0, q.ps};
      end
      ADDR_CNTH: rdByte = q.cnt[15:8];
      ADDR_CNTL: rdByte = q.lowLat ? q.lowBuf : q.cnt[7:0];
      ADDR_MODH: rdByte = q.mod[15:8];
      ADDR_MODL: rdByte = q.mod[7:0];
      ADDR_CH0CTL: begin
        rdByte = {q.ch[0].flag, q.ch[0].ie, q.ch[0].msB, q.ch[0].msA,
                  q.ch[0].els, 2'b00};
      end
      ADDR_CH1CTL: begin
        rdByte = chOn[1] ? {q.ch[1].flag, q.ch[1].ie, 1'b0, q.ch[1].msA,
                            q.ch[1].els, 2'b00} : 8'h00;
      end
      ADDR_CH0VH: rdByte = q.ch[0].val[15:8];
      ADDR_CH0VL: rdByte = q.ch[0].val[7:0];
      ADDR_CH1VH: rdByte = q.ch[1].val[15:8];
      ADDR_CH1VL: rdByte = q.ch[1].val[7:0];
      ADDR_BRKCFG: rdByte = {7'h00, q.break_clear_enable};
      default: rdByte = 8'h00;
    endcase

    // read side effects happen once, at the edge that loads prdata
    // a master that gives up after that edge has still armed the clears
    if (rdCap) begin
      d.prdata = {24'h000000, rdByte};
      case (apbReq.paddr)
        ADDR_CTRL: begin
          if (q.ovf && !brkLock) begin
            d.ovfArm = 1'b1;
          end
        end
        ADDR_CNTH: begin
          if (!q.lowLat) begin
            d.lowBuf = q.cnt[7:0];
            d.lowLat = 1'b1;
          end
        end
        ADDR_CNTL: d.lowLat = 1'b0;
        ADDR_CH0CTL: begin
          if (q.ch[0].flag && !brkLock) begin
            d.ch[0].arm = 1'b1;
          end
        end
        ADDR_CH1CTL: begin
          if (chOn[1] && q.ch[1].flag && !brkLock) begin
            d.ch[1].arm = 1'b1;
          end
        end
        // read of high byte blocks capture
        ADDR_CH0VH: d.ch[0].inh = capMode[0] ? 1'b1 : q.ch[0].inh;
        ADDR_CH0VL: d.ch[0].inh = capMode[0] ? 1'b0 : q.ch[0].inh;
        ADDR_CH1VH: d.ch[1].inh = capMode[1] ? 1'b1 : q.ch[1].inh;
        ADDR_CH1VL: d.ch[1].inh = capMode[1] ? 1'b0 : q.ch[1].inh;
        default: d.prdata = {24'h000000, rdByte};
      endcase
    end

    //////////////////////////////////////////////////////////////////////
    // writes land at the completing edge, where pready is sampled high
    // a low byte write leaves the high byte as it is
    if (wrDone) begin
      case (apbReq.paddr)
        ADDR_CTRL: begin
          d.ovfIe = wb[CTRL_IE];
          d.stop = wb[CTRL_STOP];
          d.ps = wb[CTRL_PS_LO +: 3];
          ovfClr = !wb[CTRL_FLAG] && q.ovfArm && !brkLock;
          if (wb[CTRL_CRST]) begin
            d.cnt = CNT_ZERO;
            d.pre = 7'h00;
            d.lowLat = 1'b0;
          end
        end
        ADDR_MODH: begin
          d.mod[15:8] = wb;
          d.modInh = 1'b1;
        end
        ADDR_MODL: begin
          d.mod[7:0] = wb;
          d.modInh = 1'b0;
        end
        ADDR_CH0CTL: begin
          d.ch[0].ie = wb[CHC_IE];
          d.ch[0].msB = wb[CHC_MSB];
          d.ch[0].msA = wb[CHC_MSA];
          d.ch[0].els = wb[CHC_ELS_LO +: 2];
          chClr[0] = !wb[CHC_FLAG] && q.ch[0].arm && !brkLock;
        end
        ADDR_CH1CTL: begin
          if (chOn[1]) begin
            d.ch[1].ie = wb[CHC_IE];
            d.ch[1].msA = wb[CHC_MSA];
            d.ch[1].els = wb[CHC_ELS_LO +: 2];
            chClr[1] = !wb[CHC_FLAG] && q.ch[1].arm && !brkLock;
          end
        end
        ADDR_CH0VH: begin
          d.ch[0].val[15:8] = wb;
          d.ch[0].inh = cmpMode[0] ? 1'b1 : q.ch[0].inh;
        end
        ADDR_CH0VL: begin
          d.ch[0].val[7:0] = wb;
          d.ch[0].inh = 1'b0;
          d.lastWr = 1'b0;
        end
        ADDR_CH1VH: begin
          d.ch[1].val[15:8] = wb;
          d.ch[1].inh = cmpMode[1] ? 1'b1 : q.ch[1].inh;
        end
        ADDR_CH1VL: begin
          d.ch[1].val[7:0] = wb;
          d.ch[1].inh = 1'b0;
          d.lastWr = 1'b1;
        end
        ADDR_BRKCFG: d.break_clear_enable = wb[BRK_CLREN];
        default: d.break_clear_enable = q.break_clear_enable;
      endcase
    end

    //////////////////////////////////////////////////////////////////////
    // set beats clear; an event also cancels a half-done clear
    // pending overflow kept
    if (ovfEv && !q.modInh) begin
      d.ovf = 1'b1;
      d.ovfArm = 1'b0;
    end else if (ovfClr) begin
      d.ovf = 1'b0;
      d.ovfArm = 1'b0;
    end
    // requests are registered from the next flag value, so they change in the same cycle as their flag
    // overflow request
    d.ovfIrq = d.ovf & d.ovfIe & ~d.modInh;
    for (int i = 0; i < 2; i++) begin
      if (chEv[i]) begin
        d.ch[i].flag = 1'b1;
        d.ch[i].arm = 1'b0;
      end else if (chClr[i]) begin
        d.ch[i].flag = 1'b0;
        d.ch[i].arm = 1'b0;
      end
      d.ch[i].irq = d.ch[i].flag & d.ch[i].ie;
    end

    //////////////////////////////////////////////////////////////////////
    // synchronous reset overrides every next value computed above
    // pins idle high, the preset level for mode A at 0
    if (!nrst) begin
      d = '0;
      d.stop = RST_STOP;
      d.mod = RST_MOD;
      d.ch[0].pinOut = 1'b1;
      d.ch[1].pinOut = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // the only storage of the block
  always_ff @(posedge clk) begin
    q <= d;
  end

  // every output is a bit of the registered state
  // so no decode glitch can reach a pin or a request line
  assign pready   = q.pready;
  assign pslverr  = q.pslverr;
  assign prdata   = q.prdata;
  assign ovfIrq   = q.ovfIrq;
  assign chIrq    = {q.ch[1].irq, q.ch[0].irq};
  assign chOut    = {q.ch[1].pinOut, q.ch[0].pinOut};
  assign chOe     = {q.ch[1].pinOe, q.ch[0].pinOe};

endmodule : tct_timer

`default_nettype wire

/* File: sim/tct_timer_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module tct_timer_properties
  import tct_pkg::*;
#(
  parameter bit HAS_EXT_CLK = 1'b1
) (
  input wire logic                  clk,
  input wire logic                  nrst,
  input wire tct_pkg::tct_apb_req_s apbReq,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic [31:0]           prdata,
  input wire logic                  breakActive,
  input wire logic                  extClk,
  input wire logic [1:0]            chIn,
  input wire logic [1:0]            chOut,
  input wire logic [1:0]            chOe,
  input wire logic                  ovfIrq,
  input wire logic [1:0]            chIrq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  wire logic       rdDone;
  wire logic [7:0] pa;
  assign rdDone = pready && !apbReq.pwrite;
  assign pa     = apbReq.paddr;
  ////////////////////////////////////////
  a_reset_quiet: assert property ($rose(nrst) |-> !pready && !ovfIrq && chIrq == 2'h0
    && chOe == 2'h0 && chOut == 2'h3) else $error("outputs not idle after reset");
  a_ready_one_wait: assert property ($rose(apbReq.psel && apbReq.penable) |=> pready)
    else $error("ready not one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
  a_err_unmapped: assert property (pready |-> pslverr == (pa > ADDR_BRKCFG || pa[1:0] != 2'h0))
    else $error("error flag wrong for address");
  a_err_zero_data: assert property (rdDone && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_reset_bit_zero: assert property (rdDone && pa == ADDR_CTRL |-> !prdata[CTRL_CRST])
    else $error("counter reset bit read as one");
  a_ovf_irq_follow: assert property (rdDone && pa == ADDR_CTRL && (prdata[7] || !prdata[6])
    |-> ##2 ovfIrq == prdata[CTRL_IE]) else $error("overflow request wrong");
  a_ch_irq_follow: assert property (rdDone && pa == ADDR_CH0CTL && (prdata[7] || !prdata[6])
    |-> ##2 chIrq[0] == prdata[CHC_IE]) else $error("channel request wrong");
  a_ch1_no_buffer: assert property (rdDone && pa == ADDR_CH1CTL |-> !prdata[CHC_MSB])
    else $error("second channel shows buffered bit");
  a_preset_level: assert property (rdDone && pa == ADDR_CH0CTL && prdata[3:2] == ELS_PORT
    |=> !chOe[0] && chOut[0] == !prdata[CHC_MSA]) else $error("preset pin level wrong");
endmodule : tct_timer_properties

bind tct_timer tct_timer_properties #(.HAS_EXT_CLK(HAS_EXT_CLK)) props (
  .clk(clk), .nrst(nrst), .apbReq(apbReq), .pready(pready), .pslverr(pslverr),
  .prdata(prdata), .breakActive(breakActive), .extClk(extClk), .chIn(chIn),
  .chOut(chOut), .chOe(chOe), .ovfIrq(ovfIrq), .chIrq(chIrq)
);
`default_nettype wire

/* File: sim/tct_timer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module tct_timer_bench;
  import tct_pkg::*;
  logic         clk;
  logic         nrst;
  tct_apb_req_s req;
  logic         pready;
  logic         pslverr;
  logic [31:0]  prdata;
  logic         brk;
  logic         extClk;
  logic [1:0]   chIn;
  logic [1:0]   chOut;
  logic [1:0]   chOe;
  logic         ovfIrq;
  logic [1:0]   chIrq;
  logic [7:0]   a;
  logic [32:0]  expQ[$];
  int           failures;
  int           testsRun;
  int           cyc;
  int           n;

  tct_timer dut (
    .clk(clk), .nrst(nrst), .apbReq(req), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .breakActive(brk), .extClk(extClk), .chIn(chIn),
    .chOut(chOut), .chOe(chOe), .ovfIrq(ovfIrq), .chIrq(chIrq)
  );

  always #4 clk = ~clk;
  ////////////////////////////////////////
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    testsRun++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", testsRun, failures);
    if (failures == 0 && testsRun > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  // request held until the edge that sees ready, then released
  task automatic xf(input logic w, input logic [7:0] ad, input logic [7:0] d, input logic [32:0] e);
    if (!w) expQ.push_back(e);
    req <= '{1'b1, 1'b0, w, ad, {24'h0, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (!pready);
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk);
  endtask : xf

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    xf(1'b1, ad, d, 33'h0);
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    xf(1'b0, ad, 8'h0, {25'h0, e});
  endtask : rd

  // read data compared with the oldest note; the cycle limit cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (req.psel && req.penable && pready && !req.pwrite && expQ.size() > 0) begin
      check({pslverr, prdata}, expQ.pop_front());
    end
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end

  initial begin
    clk      = 1'b0;
    nrst     = 1'b0;
    req      = '0;
    brk      = 1'b0;
    extClk   = 1'b0;
    chIn     = 2'h0;
    failures = 0;
    testsRun = 0;
    cyc      = 0;
    void'($urandom(90913));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(ADDR_CTRL, 8'h20);
    rd(ADDR_MODH, 8'hFF);
    rd(ADDR_MODL, 8'hFF);
    rd(ADDR_CH0CTL, 8'h00);
    wr(8'h30, 8'hFF);
    xf(1'b0, 8'h30, 8'h0, {1'b1, 32'h0});
    xf(1'b0, 8'h06, 8'h0, {1'b1, 32'h0});
    // a window of 8 divided ticks gives exactly 8 counts
    for (int ps = 0; ps < 7; ps++) begin
      wr(ADDR_CTRL, 8'h30 | 8'(ps));
      rd(ADDR_CNTL, 8'h00);
      wr(ADDR_CTRL, 8'(ps));
      repeat ((8 << ps) - 4) @(posedge clk);
      wr(ADDR_CTRL, 8'h20 | 8'(ps));
      rd(ADDR_CTRL, 8'h20 | 8'(ps));
      rd(ADDR_CNTL, 8'h08);
    end
    n = $urandom_range(12, 3);
    wr(ADDR_CTRL, 8'h37);
    wr(ADDR_CTRL, 8'h07);
    repeat (n) begin
      extClk <= 1'b1;
      repeat (2) @(posedge clk);
      extClk <= 1'b0;
      repeat (2) @(posedge clk);
    end
    wr(ADDR_CTRL, 8'h27);
    rd(ADDR_CNTL, 8'(n));
    // a second high read keeps the first low copy
    wr(ADDR_CTRL, 8'h30);
    wr(ADDR_CTRL, 8'h00);
    repeat (4) @(posedge clk);
    wr(ADDR_CTRL, 8'h20);
    rd(ADDR_CNTH, 8'h00);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CNTH, 8'h00);
    rd(ADDR_CNTL, 8'h08);
    wr(ADDR_CTRL, 8'h20);
    rd(ADDR_CNTL, 8'h14);
    // wrap at a short modulo, then the clearing sequence
    wr(ADDR_CTRL, 8'h30);
    wr(ADDR_MODH, 8'h00);
    wr(ADDR_MODL, 8'h03);
    // counter left running while an overflow request is wanted
    wr(ADDR_CTRL, 8'h40);
    repeat (10) @(posedge clk);
    wr(ADDR_CTRL, 8'h60);
    rd(ADDR_CNTL, 8'h02);
    rd(ADDR_CTRL, 8'hE0);
    check({32'h0, ovfIrq}, 33'h1);
    wr(ADDR_CTRL, 8'hE0);
    rd(ADDR_CTRL, 8'hE0);
    wr(ADDR_CTRL, 8'h60);
    rd(ADDR_CTRL, 8'h60);
    // an overflow after the read voids the zero write
    wr(ADDR_CTRL, 8'h40);
    repeat (8) @(posedge clk);
    rd(ADDR_CTRL, 8'hC0);
    repeat (8) @(posedge clk);
    wr(ADDR_CTRL, 8'h40);
    wr(ADDR_CTRL, 8'h20);
    rd(ADDR_CTRL, 8'hA0);
    // high byte alone mutes the flag
    wr(ADDR_CTRL, 8'h30);
    rd(ADDR_CTRL, 8'h20);
    wr(ADDR_MODH, 8'h00);
    wr(ADDR_CTRL, 8'h00);
    repeat (20) @(posedge clk);
    wr(ADDR_CTRL, 8'h20);
    rd(ADDR_CTRL, 8'h20);
    wr(ADDR_MODL, 8'h03);
    wr(ADDR_CTRL, 8'h10);
    repeat (20) @(posedge clk);
    wr(ADDR_CTRL, 8'h20);
    rd(ADDR_CTRL, 8'hA0);
    // protected flag in break, arm survives it
    brk <= 1'b1;
    wr(ADDR_CTRL, 8'h10);
    repeat (20) @(posedge clk);
    rd(ADDR_CNTL, 8'h00);
    wr(ADDR_CTRL, 8'h20);
    rd(ADDR_CTRL, 8'hA0);
    brk <= 1'b0;
    wr(ADDR_CTRL, 8'h20);
    rd(ADDR_CTRL, 8'h20);
    wr(ADDR_BRKCFG, 8'h01);
    wr(ADDR_CTRL, 8'h10);
    repeat (8) @(posedge clk);
    brk <= 1'b1;
    wr(ADDR_CTRL, 8'h20);
    rd(ADDR_CTRL, 8'hA0);
    wr(ADDR_CTRL, 8'h20);
    brk <= 1'b0;
    rd(ADDR_CTRL, 8'h20);
    // every capture edge code on both channels
    for (int c = 0; c < 2; c++) begin
      for (int e = 1; e < 4; e++) begin
        a = ADDR_CH0CTL + 8'(4 * c);
        wr(a, 8'h40 | 8'(e << 2));
        chIn[c] <= 1'b1;
        repeat (4) @(posedge clk);
        rd(a, {e[0], 3'h4, e[1:0], 2'h0});
        wr(a, 8'h40 | 8'(e << 2));
        chIn[c] <= 1'b0;
        repeat (4) @(posedge clk);
        rd(a, {e[1], 3'h4, e[1:0], 2'h0});
      end
    end
    // mode changed only with counter stopped and reset
    wr(ADDR_CH0VH, 8'h00);
    wr(ADDR_CH0VL, 8'h02);
    for (int e = 2; e < 4; e++) begin
      wr(ADDR_CTRL, 8'h30);
      wr(ADDR_CH0CTL, 8'h10 | 8'(e << 2));
      wr(ADDR_CTRL, 8'h00);
      repeat (4) @(posedge clk);
      wr(ADDR_CTRL, 8'h20);
      rd(ADDR_CH0CTL, 8'h90 | 8'(e << 2));
      check({32'h0, chOut[0]}, {32'h0, e[0]});
      check({32'h0, chOe[0]}, 33'h1);
    end
    // preset level, then linked pair hides channel one
    wr(ADDR_CH0CTL, 8'h10);
    rd(ADDR_CH0CTL, 8'h10);
    wr(ADDR_CH0CTL, 8'h20);
    wr(ADDR_CH1CTL, 8'h44);
    rd(ADDR_CH1CTL, 8'h00);
    rd(ADDR_CH0CTL, 8'h20);
    complete_run();
  end
endmodule : tct_timer_bench
`default_nettype wire
